// ==== hw/pgm_port.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1: Each pin is a software I/O or, when selected, driven by its peripheral.
// R2: Only the two thermistor pins can be routed to the converter input.
// R3: Each pin has software pull-up and pull-down selection, or floats.
// R4: A software pin is input or output, push-pull or open-drain, per pin.
// R5: Each software pin has its own separately enabled interrupt.
// R6: Edge interrupts fire on a rising or falling input edge per pin.
// R7: Level interrupts fire while the input is high or low per pin.
// R8: Pins 3 and 10 drive only open-drain as software I/O (a peripheral may drive them high) and never pull up.
// R9: After reset pins 2,5,18,19 go to their peripheral, the rest to input.
// R10: Armed role-swap pins toggle in hardware on swap detect or send.
// R11: Software picks pin 7, 13, 15 or 17 as the non-maskable source.
// R12: Pin interrupts latch sticky flags merged into one enabled request.
module pgm_port
  import pgm_pkg::*;
#(
  parameter int NPIN = PGM_NPIN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration write, one pin at a time
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_idx,
  input wire pgm_pin_cfg_s cfg_wdata,
  // Interrupt control
  input wire logic [NPIN-1:0] pend_clr,
  input wire logic nmi_en,
  input wire logic [1:0] nmi_sel,
  // Fast role swap
  input wire pgm_frs_s frs,
  // Peripheral side of the pins
  input wire logic [NPIN-1:0] periph_out,
  input wire logic [NPIN-1:0] periph_oe,
  // Pads
  input wire logic [NPIN-1:0] pad_in,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe,
  output logic [NPIN-1:0] pad_pull_up,
  output logic [NPIN-1:0] pad_pull_dn,
  // Status to software
  output logic [NPIN-1:0] gpio_in,
  output logic [NPIN-1:0] pend,
  output logic irq,
  output logic nmi,
  // Analog routing and role-swap state
  output logic thermistor_input_a,
  output logic thermistor_input_b,
  output logic role_path_select_port_a,
  output logic role_path_select_port_b,
  output logic sink_path_enable_port_a,
  output logic sink_path_enable_port_b
);

  generate
    if (NPIN != PGM_NPIN) begin : g_bad_npin
      $error("pgm_port: pin masks are fixed at 20 pins");
    end
  endgenerate

  pgm_pin_cfg_s cfg [NPIN];
  logic [NPIN-1:0] role_drive;
  logic [NPIN-1:0] irq_mask;
  logic [NPIN-1:0] next_out;
  logic [NPIN-1:0] next_oe;
  logic [NPIN-1:0] next_pu;
  logic [NPIN-1:0] next_pd;
  logic [4:0] nmi_pin;
  logic [1:0] frs_evt;

  // Power-up function and pulls per pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NPIN; i++) begin
        cfg[i] <= '0;
        cfg[i].mode <= PGM_DFLT_PERIPH[i] ? PGM_MODE_PERIPH
                                          : PGM_MODE_GPIO; // [R9]
        cfg[i].pull_up <= PGM_DFLT_PULLUP[i]; // [R9]
      end
    end else if (cfg_wr && (int'(cfg_idx) < NPIN)) begin
      cfg[cfg_idx] <= cfg_wdata;
    end
  end

  // Role-swap pins flip without firmware in the loop
  assign frs_evt = frs.arm & (frs.detect | frs.tx);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      role_path_select_port_a <= PGM_ROLE_PATH_RST;
      sink_path_enable_port_a <= PGM_SINK_PATH_RST;
    end else if (frs_evt[0]) begin
      role_path_select_port_a <= ~role_path_select_port_a; // [R10]
      sink_path_enable_port_a <= ~sink_path_enable_port_a; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      role_path_select_port_b <= PGM_ROLE_PATH_RST;
      sink_path_enable_port_b <= PGM_SINK_PATH_RST;
    end else if (frs_evt[1]) begin
      role_path_select_port_b <= ~role_path_select_port_b; // [R10]
      sink_path_enable_port_b <= ~sink_path_enable_port_b; // [R10]
    end
  end

  always_comb begin
    role_drive = '0;
    role_drive[PGM_ROLE_PATH_A] = role_path_select_port_a;
    role_drive[PGM_ROLE_PATH_B] = role_path_select_port_b;
    role_drive[PGM_SINK_PATH_A] = sink_path_enable_port_a;
    role_drive[PGM_SINK_PATH_B] = sink_path_enable_port_b;
  end

  // Pad drive per function
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      next_out[i] = 1'b0;
      next_oe[i] = 1'b0;
      next_pu[i] = cfg[i].pull_up & ~PGM_OD_ONLY[i]; // [R3] [R8]
      next_pd[i] = cfg[i].pull_dn; // [R3]
      case (cfg[i].mode)
        PGM_MODE_GPIO: begin
          if (cfg[i].open_drain || PGM_OD_ONLY[i]) begin
            next_oe[i] = cfg[i].dir_out & ~cfg[i].dout; // [R4] [R8]
          end else begin
            next_oe[i] = cfg[i].dir_out; // [R4]
            next_out[i] = cfg[i].dout;
          end
        end
        PGM_MODE_PERIPH: begin
          next_oe[i] = periph_oe[i]; // [R1]
          next_out[i] = periph_out[i]; // [R1]
        end
        PGM_MODE_ROLE: begin
          next_oe[i] = PGM_ROLE_OK[i];
          next_out[i] = PGM_ROLE_OK[i] & role_drive[i]; // [R10]
        end
        PGM_MODE_ANALOG: begin
          // Pulls would bias the analog reading
          next_pu[i] = 1'b0;
          next_pd[i] = 1'b0;
        end
        default: begin
          next_oe[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_pull_up <= PGM_DFLT_PULLUP;
      pad_pull_dn <= '0;
      gpio_in <= '0;
    end else begin
      pad_out <= next_out;
      pad_oe <= next_oe;
      pad_pull_up <= next_pu;
      pad_pull_dn <= next_pd;
      gpio_in <= pad_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      thermistor_input_a <= 1'b0;
      thermistor_input_b <= 1'b0;
    end else begin
      thermistor_input_a <= PGM_ANALOG_OK[PGM_THERM_A] &&
        (cfg[PGM_THERM_A].mode == PGM_MODE_ANALOG); // [R2]
      thermistor_input_b <= PGM_ANALOG_OK[PGM_THERM_B] &&
        (cfg[PGM_THERM_B].mode == PGM_MODE_ANALOG); // [R2]
    end
  end

  // Interrupt detection, one instance per pin
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      assign irq_mask[g] = cfg[g].irq_en && (cfg[g].mode == PGM_MODE_GPIO);
      pgm_pin_irq u_irq (
        .clk(clk),
        .nrst(nrst),
        .din(pad_in[g]),
        .en(irq_mask[g]), // [R5]
        .level_mode(cfg[g].irq_level),
        .pol(cfg[g].irq_pol),
        .clr(pend_clr[g]),
        .pend(pend[g])
      );
    end
  endgenerate

  always_comb begin
    case (nmi_sel)
      2'h0: nmi_pin = PGM_NMI_PIN0;
      2'h1: nmi_pin = PGM_NMI_PIN1;
      2'h2: nmi_pin = PGM_NMI_PIN2;
      default: nmi_pin = PGM_NMI_PIN3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
      nmi <= 1'b0;
    end else begin
      irq <= |(pend & irq_mask); // [R12]
      nmi <= nmi_en & pend[nmi_pin]; // [R11]
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_reset_defaults: assert property ( // [R9]
    @(posedge clk) disable iff (1'b0)
    !nrst |=> pad_oe == '0 && pad_pull_up == PGM_DFLT_PULLUP)
    else $error("reset defaults wrong");
  a_od_never_high: assert property ( // [R8]
    (pad_pull_up & PGM_OD_ONLY) == '0)
    else $error("open-drain pin pulled high");
  // Peripherals may still drive these pins high, so only software use counts
  a_od_low_drive: assert property ( // [R8]
    cfg[PGM_OPEN_DRAIN_IO_LOW].mode == PGM_MODE_GPIO
    |=> !pad_out[PGM_OPEN_DRAIN_IO_LOW])
    else $error("open-drain pin driven high");
  a_od_high_drive: assert property ( // [R8]
    cfg[PGM_OPEN_DRAIN_IO_HIGH].mode == PGM_MODE_GPIO
    |=> !pad_out[PGM_OPEN_DRAIN_IO_HIGH])
    else $error("open-drain pin driven high");
  a_gpio_push_pull: assert property ( // [R4]
    cfg[5].mode == PGM_MODE_GPIO && cfg[5].dir_out && !cfg[5].open_drain
    |=> pad_oe[5] && pad_out[5] == $past(cfg[5].dout))
    else $error("push-pull output wrong");
  a_periph_takeover: assert property ( // [R1]
    cfg[4].mode == PGM_MODE_PERIPH |=> pad_oe[4] == $past(periph_oe[4]))
    else $error("peripheral did not own pin");
  a_pull_follows: assert property ( // [R3]
    cfg[7].mode == PGM_MODE_GPIO |=> pad_pull_dn[7] == $past(cfg[7].pull_dn))
    else $error("pull-down not applied");
  a_analog_route: assert property ( // [R2]
    thermistor_input_a |-> $past(cfg[PGM_THERM_A].mode) == PGM_MODE_ANALOG)
    else $error("analog route without analog mode");
  a_frs_toggle: assert property ( // [R10]
    frs_evt[0] |=> role_path_select_port_a != $past(role_path_select_port_a))
    else $error("role path did not toggle");
  a_nmi_select: assert property ( // [R11]
    nmi_en && nmi_sel == 2'h1 && pend[12] |=> nmi)
    else $error("selected NMI pin ignored");
  a_irq_combine: assert property ( // [R12]
    (pend & irq_mask) != '0 |=> irq)
    else $error("enabled pending gave no request");

  c_irq_seen: cover property ($rose(irq));
  c_frs_swap: cover property (frs_evt[1] ##1 frs_evt[1]);
  c_nmi_seen: cover property ($rose(nmi));

endmodule

// ==== hw/pgm_pkg.sv ====
package pgm_pkg;

  localparam int PGM_NPIN = 20;

  // Pin function select codes
  localparam logic [1:0] PGM_MODE_GPIO = 2'h0;
  localparam logic [1:0] PGM_MODE_PERIPH = 2'h1;
  localparam logic [1:0] PGM_MODE_ROLE = 2'h2;
  localparam logic [1:0] PGM_MODE_ANALOG = 2'h3;

  // Pin masks, bit n is port pin n+1
  localparam logic [19:0] PGM_OD_ONLY = 20'h00204;
  localparam logic [19:0] PGM_ANALOG_OK = 20'h84000;
  localparam logic [19:0] PGM_ROLE_OK = 20'h86001;
  localparam logic [19:0] PGM_DFLT_PERIPH = 20'h60012;
  localparam logic [19:0] PGM_DFLT_PULLUP = 20'h69012;

  // Pin indices of named functions
  localparam int PGM_OPEN_DRAIN_IO_LOW = 2;
  localparam int PGM_OPEN_DRAIN_IO_HIGH = 9;
  localparam int PGM_ROLE_PATH_A = 0;
  localparam int PGM_ROLE_PATH_B = 13;
  localparam int PGM_SINK_PATH_B = 14;
  localparam int PGM_SINK_PATH_A = 19;
  localparam int PGM_THERM_B = 14;
  localparam int PGM_THERM_A = 19;

  // External NMI candidate pins, selected by a 2-bit code
  localparam logic [4:0] PGM_NMI_PIN0 = 5'h06;
  localparam logic [4:0] PGM_NMI_PIN1 = 5'h0c;
  localparam logic [4:0] PGM_NMI_PIN2 = 5'h0e;
  localparam logic [4:0] PGM_NMI_PIN3 = 5'h10;

  // Reset value of the role-swap outputs
  localparam logic PGM_ROLE_PATH_RST = 1'b1;
  localparam logic PGM_SINK_PATH_RST = 1'b0;

  typedef struct packed {
    logic [1:0] mode;
    logic dir_out;
    logic dout;
    logic open_drain;
    logic pull_up;
    logic pull_dn;
    logic irq_en;
    logic irq_level;
    logic irq_pol;
  } pgm_pin_cfg_s;

  typedef struct packed {
    logic [1:0] arm;
    logic [1:0] detect;
    logic [1:0] tx;
  } pgm_frs_s;

endpackage

// ==== hw/pgm_pin_irq.sv ====
`timescale 1ns/1ps
module pgm_pin_irq
  import pgm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin and its settings
  input wire logic din,
  input wire logic en,
  input wire logic level_mode,
  input wire logic pol,
  input wire logic clr,
  // Pending flag
  output logic pend
);

  logic prev;
  logic primed;
  logic hit;

  // No edge seen until one real sample follows reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev <= din;
      primed <= 1'b1;
    end
  end

  always_comb begin
    if (level_mode) begin
      hit = en & (din == pol); // [R7]
    end else begin
      hit = en & primed & (pol ? (din & ~prev) : (~din & prev)); // [R6]
    end
  end

  // A hit in the clear cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend <= 1'b0;
    end else if (hit) begin
      pend <= 1'b1; // [R5] [R12]
    end else if (clr) begin
      pend <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_edge_sets_pend: assert property ( // [R6]
    en && !level_mode && primed && (pol ? (din && !prev) : (!din && prev))
    |=> pend)
    else $error("edge did not set pending");
  a_level_sets_pend: assert property ( // [R7]
    en && level_mode && (din == pol) |=> pend)
    else $error("level did not set pending");
  a_pend_sticky: assert property ( // [R12]
    pend && !clr |=> pend)
    else $error("pending dropped without clear");
  a_disabled_quiet: assert property ( // [R5]
    !pend && !en |=> !pend)
    else $error("disabled pin raised pending");
  a_clear_works: assert property ( // [R12]
    pend && clr && !hit |=> !pend)
    else $error("clear did not drop pending");

endmodule

// ==== sim/pgm_board.sv ====
`timescale 1ns/1ps
module pgm_board
  import pgm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pad drive from the port
  input wire logic [PGM_NPIN-1:0] pad_out,
  input wire logic [PGM_NPIN-1:0] pad_oe,
  input wire logic [PGM_NPIN-1:0] pad_pull_up,
  input wire logic [PGM_NPIN-1:0] pad_pull_dn,
  // Board drivers set by the bench
  input wire logic [PGM_NPIN-1:0] ext_val,
  input wire logic [PGM_NPIN-1:0] ext_drv,
  // Resolved pad level
  output logic [PGM_NPIN-1:0] pad_in
);
  logic [PGM_NPIN-1:0] last = '0;
  // Floating pads wander, so no test may lean on a stale level
  always @(posedge clk) begin
    last <= pad_in;
  end
  always_comb begin
    for (int i = 0; i < PGM_NPIN; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_drv[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else if (pad_pull_dn[i]) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = ~last[i];
      end
    end
  end
endmodule

// ==== sim/port_gpio_pin_mux_test.sv ====
`timescale 1ns/1ps
module port_gpio_pin_mux_test;
  import pgm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr = 1'b0;
  logic [4:0] cfg_idx = 5'h00;
  pgm_pin_cfg_s cfg_wdata = '0;
  logic [19:0] pend_clr = 20'h00000;
  logic nmi_en = 1'b0;
  logic [1:0] nmi_sel = 2'h0;
  pgm_frs_s frs = '0;
  logic [19:0] periph_out = 20'h00000;
  logic [19:0] periph_oe = 20'h00000;
  logic [19:0] ext_val = 20'h00000;
  logic [19:0] ext_drv = 20'h00000;
  logic [19:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_dn;
  logic [19:0] gpio_in, pend;
  logic irq, nmi, th_a, th_b, role_a, role_b, sink_a, sink_b;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  pgm_port pgm_port_inst (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr),
    .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .pend_clr(pend_clr),
    .nmi_en(nmi_en), .nmi_sel(nmi_sel), .frs(frs),
    .periph_out(periph_out), .periph_oe(periph_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_dn(pad_pull_dn), .gpio_in(gpio_in), .pend(pend),
    .irq(irq), .nmi(nmi), .thermistor_input_a(th_a),
    .thermistor_input_b(th_b), .role_path_select_port_a(role_a),
    .role_path_select_port_b(role_b), .sink_path_enable_port_a(sink_a),
    .sink_path_enable_port_b(sink_b));

  pgm_board pgm_board_inst (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
    .ext_val(ext_val), .ext_drv(ext_drv), .pad_in(pad_in));

  task automatic close_out;
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Flags: dir_out dout open_drain pull_up pull_dn irq_en level pol
  function automatic pgm_pin_cfg_s mk(input logic [1:0] m,
                                      input logic [7:0] f);
    return {m, f};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Returns once the pads show the new setting
  task automatic wr(input logic [4:0] idx, input pgm_pin_cfg_s c);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_idx = idx;
    cfg_wdata = c;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset;
    check("pull_up", pad_pull_up, 20'h69012);
    check("pad_oe", pad_oe, 20'h00000);
    check("pull_dn", pad_pull_dn, 20'h00000);
    check("role", 20'({role_a, role_b, sink_a, sink_b}), 20'h0000c);
  endtask

  task automatic t_periph;
    periph_oe = 20'hfffff;
    periph_out = 20'h00012;
    tick(2);
    check("periph oe", pad_oe, 20'h60012);
    check("periph out", pad_out, 20'h00012);
    wr(5'h0a, mk(2'h1, 8'h00));
    check("periph take", pad_oe, 20'h60412);
    wr(5'h0a, mk(2'h0, 8'h00));
    periph_oe = 20'h00000;
  endtask

  task automatic t_drive;
    wr(5'h05, mk(2'h0, 8'hc0));
    check("pp", 20'({pad_oe[5], pad_out[5]}), 20'h3);
    wr(5'h05, mk(2'h0, 8'he0));
    check("od high", 20'({pad_oe[5], pad_out[5]}), 20'h0);
    wr(5'h05, mk(2'h0, 8'ha0));
    check("od low", 20'({pad_oe[5], pad_out[5]}), 20'h2);
    wr(5'h02, mk(2'h0, 8'hd0));
    check("od3", 20'({pad_oe[2], pad_pull_up[2]}), 20'h0);
    wr(5'h09, mk(2'h0, 8'h90));
    check("od10", 20'({pad_oe[9], pad_out[9], pad_pull_up[9]}), 20'h4);
    wr(5'h07, mk(2'h0, 8'h08));
    check("pull dn", 20'({pad_pull_up[7], pad_pull_dn[7]}), 20'h1);
    wr(5'h07, mk(2'h0, 8'h10));
    check("pull up", 20'({pad_pull_up[7], pad_pull_dn[7]}), 20'h2);
  endtask

  task automatic t_edge;
    logic [4:0] pins [4] = '{5'h06, 5'h0c, 5'h0e, 5'h10};
    logic [4:0] p;
    logic pol;
    nmi_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      p = pins[k];
      pol = k[0];
      nmi_sel = k[1:0];
      ext_drv[p] = 1'b1;
      ext_val[p] = ~pol;
      wr(p, mk(2'h0, {5'h00, 1'b1, 1'b0, pol}));
      check("pend idle", pend, 20'h00000);
      ext_val[p] = pol;
      tick(3);
      check("pend edge", pend, 20'h00001 << p);
      check("irq nmi", 20'({irq, nmi}), 20'h3);
      check("gpio in", 20'(gpio_in[p]), 20'(pol));
      pend_clr[p] = 1'b1;
      tick(1);
      pend_clr = 20'h00000;
      tick(2);
      check("cleared", 20'({pend[p], irq, nmi}), 20'h0);
      wr(p, mk(2'h0, 8'h00));
    end
  endtask

  task automatic t_level;
    logic pol;
    for (int k = 0; k < 2; k++) begin
      pol = k[0];
      ext_drv[8] = 1'b1;
      ext_val[8] = ~pol;
      wr(5'h08, mk(2'h0, {5'h00, 1'b1, 1'b1, pol}));
      tick(2);
      check("lvl idle", pend, 20'h00000);
      ext_val[8] = pol;
      tick(3);
      check("lvl set", 20'({pend[8], irq}), 20'h3);
      pend_clr[8] = 1'b1;
      tick(1);
      pend_clr = 20'h00000;
      tick(2);
      check("lvl held", pend, 20'h00100);
      ext_val[8] = ~pol;
      tick(2);
      pend_clr[8] = 1'b1;
      tick(1);
      pend_clr = 20'h00000;
      tick(2);
      check("lvl clr", 20'({pend[8], irq}), 20'h0);
      // Old polarity would re-arm the flag while the pin is moved
      wr(5'h08, mk(2'h0, 8'h00));
    end
  endtask

  task automatic t_analog;
    wr(5'h13, mk(2'h3, 8'h00));
    check("therm a", 20'({th_a, th_b, pad_oe[19]}), 20'h4);
    wr(5'h00, mk(2'h3, 8'h00));
    check("no therm", 20'({th_a, th_b}), 20'h2);
    wr(5'h0e, mk(2'h3, 8'h00));
    check("therm b", 20'({th_a, th_b}), 20'h3);
  endtask

  task automatic t_frs;
    frs = '{arm: 2'b01, detect: 2'b01, tx: 2'b00};
    tick(1);
    frs.detect = 2'b00;
    tick(1);
    check("frs det", 20'({role_a, role_b, sink_a, sink_b}), 20'h6);
    frs = '{arm: 2'b10, detect: 2'b01, tx: 2'b10};
    tick(1);
    frs = '{arm: 2'b10, detect: 2'b00, tx: 2'b00};
    tick(1);
    check("frs tx", 20'({role_a, role_b, sink_a, sink_b}), 20'h3);
    wr(5'h00, mk(2'h2, 8'h00));
    wr(5'h05, mk(2'h2, 8'h00));
    check("frs pad", 20'({pad_oe[0], pad_out[0], pad_oe[5]}), 20'h4);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    tick(4);
    nrst = 1'b1;
    tick(2);
    t_reset();
    t_periph();
    t_drive();
    t_edge();
    t_level();
    t_analog();
    t_frs();
    close_out();
  end
endmodule
